// ### hw/pcidr_target.sv
// The register addresses and the AXI4-Lite slave port were decided locally.
`timescale 1ns/100ps
module pcidr_target #(
  parameter int FLUSH_CLKS = pcidr_pkg::FLUSH_CLKS_DFLT
) (
  input wire logic clock,
  input wire logic rst,
  // pci side
  input wire logic pci_clk,
  input wire pcidr_pkg::pcidr_pin_in_t pci_in,
  output pcidr_pkg::pcidr_pin_out_t pci_out,
  // local side
  output pcidr_pkg::pcidr_loc_req_t loc_req,
  output logic loc_req_valid,
  input wire logic loc_req_ready,
  input wire logic loc_rd_valid,
  input wire logic [31:0] loc_rd_data,
  // axi4-lite slave
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  localparam logic [15:0] FLUSH_LAST = 16'(FLUSH_CLKS - 1);

  // pin and clock sampling
  pcidr_pkg::pcidr_pin_in_t pin_s;
  logic pclk_s;
  logic pclk_prev_q;

  pcidr_sync #(.W(pcidr_pkg::PIN_IN_W), .RST_VAL('1)) u_pin_sync (
    .clock(clock),
    .rst(rst),
    .d(pci_in),
    .q(pin_s)
  );

  pcidr_sync #(.W(1), .RST_VAL(1'b0)) u_clk_sync (
    .clock(clock),
    .rst(rst),
    .d(pci_clk),
    .q(pclk_s)
  );

  wire logic pedge = pclk_s & ~pclk_prev_q;
  wire logic frame_n = pin_s.frame_n;
  wire logic irdy_n = pin_s.irdy_n;

  // registers
  logic [31:0] mode_q;
  logic [31:0] mode_d;
  logic [31:0] lrd_q;
  logic [31:0] lrd_d;

  wire logic comply = mode_q[pcidr_pkg::COMPLY_BIT];
  wire logic no_write = mode_q[pcidr_pkg::NO_WRITE_BIT];
  wire logic wr_flush = mode_q[pcidr_pkg::WR_FLUSH_BIT];
  wire logic no_flush = mode_q[pcidr_pkg::NO_FLUSH_BIT];
  wire logic [4:0] retry_dly =
    {1'b0, lrd_q[pcidr_pkg::RETRY_DLY_LSB +: pcidr_pkg::RETRY_DLY_W]};

  // target state
  pcidr_pkg::pcidr_state_t st_q;
  pcidr_pkg::pcidr_state_t st_d;
  pcidr_pkg::pcidr_pin_out_t out_q;
  pcidr_pkg::pcidr_pin_out_t out_d;
  pcidr_pkg::pcidr_loc_req_t req_q;
  pcidr_pkg::pcidr_loc_req_t req_d;
  logic reqv_q;
  logic reqv_d;
  logic [31:0] addr_q;
  logic [31:0] addr_d;
  logic is_wr_q;
  logic is_wr_d;
  logic first_q;
  logic first_d;
  logic [4:0] lat_q;
  logic [4:0] lat_d;
  logic pend_q;
  logic pend_d;
  logic [31:0] paddr_q;
  logic [31:0] paddr_d;
  logic [3:0] pbe_q;
  logic [3:0] pbe_d;
  logic [15:0] flush_q;
  logic [15:0] flush_d;
  logic rbusy_q;
  logic rbusy_d;
  logic rok_q;
  logic rok_d;
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  wire logic [3:0] cmd = pin_s.cbe_n;
  wire logic claim = (cmd == pcidr_pkg::CMD_MEM_RD) || (cmd == pcidr_pkg::CMD_MEM_WR);
  wire logic loc_busy = reqv_q | rbusy_q;
  wire logic match = (addr_q == paddr_q) && (pin_s.cbe_n == pbe_q);
  wire logic phase_done = ~irdy_n & ~out_q.trdy_n;
  wire logic [4:0] lat_inc = (lat_q == pcidr_pkg::LAT_MAX) ? lat_q : lat_q + 5'h01;
  wire logic [3:0] rd_be_n = (comply & no_flush) ? pcidr_pkg::BE_ALL_N : pin_s.cbe_n;
  wire logic late_first = first_q && (lat_q == pcidr_pkg::FIRST_LAT_LAST);
  wire logic late_next = !first_q && (lat_q == pcidr_pkg::NEXT_LAT_LAST);

  always_comb begin
    st_d = st_q;
    out_d = out_q;
    req_d = req_q;
    reqv_d = reqv_q;
    addr_d = addr_q;
    is_wr_d = is_wr_q;
    first_d = first_q;
    lat_d = lat_q;
    pend_d = pend_q;
    paddr_d = paddr_q;
    pbe_d = pbe_q;
    flush_d = flush_q;
    rbusy_d = rbusy_q;
    rok_d = rok_q;
    rdata_d = rdata_q;
    if (pedge) begin
      lat_d = lat_inc;
      if (pend_q) begin
        if (flush_q == FLUSH_LAST) begin
          pend_d = 1'b0;
          rok_d = 1'b0;
          flush_d = '0;
        end else begin
          flush_d = flush_q + 16'h0001;
        end
      end
      case (st_q)
        pcidr_pkg::S_IDLE: begin
          if (!frame_n && claim) begin
            addr_d = pin_s.ad;
            is_wr_d = (cmd == pcidr_pkg::CMD_MEM_WR);
            lat_d = '0;
            out_d.devsel_n = 1'b0;
            out_d.ctl_oe_n = 1'b0;
            st_d = pcidr_pkg::S_DECODE;
          end
        end
        pcidr_pkg::S_DECODE: begin
          if (!irdy_n) begin
            if (is_wr_q) begin
              if (comply && pend_q && no_write) begin
                out_d.stop_n = 1'b0;
                st_d = pcidr_pkg::S_END;
              end else begin
                if (wr_flush && !no_write && pend_q) begin
                  pend_d = 1'b0;
                  rok_d = 1'b0;
                end
                out_d.trdy_n = reqv_q;
                first_d = 1'b1;
                st_d = pcidr_pkg::S_WDATA;
              end
            end else if (comply) begin
              if (!pend_q) begin
                if (!loc_busy) begin
                  pend_d = 1'b1;
                  paddr_d = addr_q;
                  pbe_d = pin_s.cbe_n;
                  flush_d = '0;
                  rok_d = 1'b0;
                  req_d = '{write: 1'b0, addr: addr_q, local_byte_enables_n: rd_be_n,
                            data: '0};
                  reqv_d = 1'b1;
                end
                out_d.stop_n = 1'b0;
                st_d = pcidr_pkg::S_END;
              end else if (match && rok_q && !rbusy_q) begin
                out_d.ad = rdata_q;
                out_d.ad_oe_n = 1'b0;
                out_d.trdy_n = 1'b0;
                out_d.stop_n = 1'b0;
                st_d = pcidr_pkg::S_RDATA;
              end else begin
                out_d.stop_n = 1'b0;
                st_d = pcidr_pkg::S_END;
              end
            end else if (loc_busy) begin
              out_d.stop_n = 1'b0;
              st_d = pcidr_pkg::S_END;
            end else begin
              req_d = '{write: 1'b0, addr: addr_q, local_byte_enables_n: rd_be_n, data: '0};
              reqv_d = 1'b1;
              rok_d = 1'b0;
              lat_d = '0;
              st_d = pcidr_pkg::S_RWAIT;
            end
          end
        end
        pcidr_pkg::S_RWAIT: begin
          if (rok_q && !rbusy_q && !reqv_q) begin
            out_d.ad = rdata_q;
            out_d.ad_oe_n = 1'b0;
            out_d.trdy_n = 1'b0;
            out_d.stop_n = 1'b0;
            st_d = pcidr_pkg::S_RDATA;
          end else if (lat_q >= retry_dly) begin
            out_d.stop_n = 1'b0;
            st_d = pcidr_pkg::S_END;
          end
        end
        pcidr_pkg::S_RDATA: begin
          if (phase_done) begin
            out_d.trdy_n = 1'b1;
            out_d.ad_oe_n = 1'b1;
            rok_d = 1'b0;
            pend_d = 1'b0;
            st_d = pcidr_pkg::S_END;
          end
        end
        pcidr_pkg::S_WDATA: begin
          if (phase_done) begin
            req_d = '{write: 1'b1, addr: addr_q, local_byte_enables_n: pin_s.cbe_n,
                      data: pin_s.ad};
            reqv_d = 1'b1;
            addr_d = addr_q + pcidr_pkg::ADDR_STEP;
            first_d = 1'b0;
            lat_d = '0;
            out_d.trdy_n = 1'b1;
            if (frame_n) begin
              st_d = pcidr_pkg::S_END;
            end
          end else if (comply && (late_first || late_next)) begin
            out_d.trdy_n = 1'b1;
            out_d.stop_n = 1'b0;
            st_d = pcidr_pkg::S_END;
          end else begin
            out_d.trdy_n = reqv_q;
          end
        end
        pcidr_pkg::S_END: begin
          out_d.trdy_n = 1'b1;
          out_d.ad_oe_n = 1'b1;
          if (frame_n) begin
            out_d.devsel_n = 1'b1;
            out_d.stop_n = 1'b1;
            out_d.ctl_oe_n = 1'b1;
            st_d = pcidr_pkg::S_IDLE;
          end
        end
        default: begin
          st_d = pcidr_pkg::S_IDLE;
        end
      endcase
    end
    // local side runs every clock; an arriving word wins over a clear
    if (reqv_q && loc_req_ready) begin
      reqv_d = 1'b0;
      if (!req_q.write) begin
        rbusy_d = 1'b1;
      end
    end
    if (loc_rd_valid && rbusy_q) begin
      rbusy_d = 1'b0;
      rok_d = 1'b1;
      rdata_d = loc_rd_data;
    end
  end

  localparam pcidr_pkg::pcidr_pin_out_t OUT_IDLE = '{devsel_n: 1'b1, trdy_n: 1'b1,
    stop_n: 1'b1, ctl_oe_n: 1'b1, ad: '0, ad_oe_n: 1'b1};

  always_ff @(posedge clock) begin
    if (rst) begin
      pclk_prev_q <= 1'b0;
      st_q <= pcidr_pkg::S_IDLE;
      out_q <= OUT_IDLE;
      req_q <= '0;
      reqv_q <= 1'b0;
      addr_q <= '0;
      is_wr_q <= 1'b0;
      first_q <= 1'b0;
      lat_q <= '0;
      pend_q <= 1'b0;
      paddr_q <= '0;
      pbe_q <= '0;
      flush_q <= '0;
      rbusy_q <= 1'b0;
      rok_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      pclk_prev_q <= pclk_s;
      st_q <= st_d;
      out_q <= out_d;
      req_q <= req_d;
      reqv_q <= reqv_d;
      addr_q <= addr_d;
      is_wr_q <= is_wr_d;
      first_q <= first_d;
      lat_q <= lat_d;
      pend_q <= pend_d;
      paddr_q <= paddr_d;
      pbe_q <= pbe_d;
      flush_q <= flush_d;
      rbusy_q <= rbusy_d;
      rok_q <= rok_d;
      rdata_q <= rdata_d;
    end
  end

  assign pci_out = out_q;
  assign loc_req = req_q;
  assign loc_req_valid = reqv_q;

  // axi4-lite slave
  logic aw_q;
  logic [11:0] awaddr_q;
  logic w_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_word_q;

  wire logic wr_go = aw_q & w_q & ~bvalid_q;
  wire logic sel_mode = (awaddr_q == pcidr_pkg::MODE_ARB_OFF);
  wire logic sel_lrd = (awaddr_q == pcidr_pkg::LOC_REGION_OFF);
  wire logic sel_stat_w = (awaddr_q == pcidr_pkg::STATUS_OFF);
  wire logic [31:0] wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}},
                              {8{wstrb_q[0]}}};
  wire logic [31:0] status_word = {{pcidr_pkg::STATUS_PAD_W{1'b0}}, rbusy_q, reqv_q,
                                    rok_q, pend_q};
  wire logic ar_go = s_axi_arvalid & ~rvalid_q;
  wire logic rd_mode = (s_axi_araddr == pcidr_pkg::MODE_ARB_OFF);
  wire logic rd_lrd = (s_axi_araddr == pcidr_pkg::LOC_REGION_OFF);
  wire logic rd_stat = (s_axi_araddr == pcidr_pkg::STATUS_OFF);
  wire logic [31:0] rd_mux = rd_mode ? mode_q : rd_lrd ? lrd_q : rd_stat ? status_word : '0;
  wire logic [1:0] rd_resp = (rd_mode | rd_lrd | rd_stat) ? pcidr_pkg::RESP_OKAY :
                             pcidr_pkg::RESP_SLVERR;
  wire logic [1:0] wr_resp = (sel_mode | sel_lrd | sel_stat_w) ? pcidr_pkg::RESP_OKAY :
                             pcidr_pkg::RESP_SLVERR;

  assign mode_d = (wr_go && sel_mode) ? ((mode_q & ~wmask) | (wdata_q & wmask)) : mode_q;
  assign lrd_d = (wr_go && sel_lrd) ? ((lrd_q & ~wmask) | (wdata_q & wmask)) : lrd_q;

  assign s_axi_awready = ~aw_q & ~bvalid_q;
  assign s_axi_wready = ~w_q & ~bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rd_word_q;

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q <= pcidr_pkg::MODE_ARB_RST;
      lrd_q <= pcidr_pkg::LOC_REGION_RST;
      aw_q <= 1'b0;
      awaddr_q <= '0;
      w_q <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
      bvalid_q <= 1'b0;
      bresp_q <= pcidr_pkg::RESP_OKAY;
    end else begin
      mode_q <= mode_d;
      lrd_q <= lrd_d;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_go) begin
        w_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_resp;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      rvalid_q <= 1'b0;
      rresp_q <= pcidr_pkg::RESP_OKAY;
      rd_word_q <= '0;
    end else if (ar_go) begin
      rvalid_q <= 1'b1;
      rresp_q <= rd_resp;
      rd_word_q <= rd_mux;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule

// ### hw/pcidr_pkg.sv
package pcidr_pkg;

  // register byte offsets on the axi4-lite slave
  localparam logic [11:0] MODE_ARB_OFF = 12'h000;
  localparam logic [11:0] LOC_REGION_OFF = 12'h004;
  localparam logic [11:0] STATUS_OFF = 12'h008;

  localparam logic [31:0] MODE_ARB_RST = 32'h00000000;
  localparam logic [31:0] LOC_REGION_RST = 32'h00000000;

  // mode_arbitration_reg fields
  localparam int COMPLY_BIT = 24;
  localparam int NO_WRITE_BIT = 25;
  localparam int WR_FLUSH_BIT = 26;
  localparam int NO_FLUSH_BIT = 28;

  // local_region_descriptor retry delay field
  localparam int RETRY_DLY_LSB = 28;
  localparam int RETRY_DLY_W = 4;

  // status word padding above the flags
  localparam int STATUS_PAD_W = 28;

  // latency limits in pci clocks
  localparam int LAT_W = 5;
  localparam logic [4:0] FIRST_LAT_LAST = 5'h0f;
  localparam logic [4:0] NEXT_LAT_LAST = 5'h07;
  localparam logic [4:0] LAT_MAX = 5'h1f;

  // delayed read flush timeout in pci clocks
  localparam int FLUSH_CLKS_DFLT = 32768;
  localparam int FLUSH_W = 16;

  localparam logic [3:0] CMD_MEM_RD = 4'h6;
  localparam logic [3:0] CMD_MEM_WR = 4'h7;
  localparam logic [3:0] BE_ALL_N = 4'h0;
  localparam logic [31:0] ADDR_STEP = 32'h00000004;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic frame_n;
    logic irdy_n;
    logic [3:0] cbe_n;
    logic [31:0] ad;
  } pcidr_pin_in_t;

  typedef struct packed {
    logic devsel_n;
    logic trdy_n;
    logic stop_n;
    logic ctl_oe_n;
    logic [31:0] ad;
    logic ad_oe_n;
  } pcidr_pin_out_t;

  typedef struct packed {
    logic write;
    logic [31:0] addr;
    logic [3:0] local_byte_enables_n;
    logic [31:0] data;
  } pcidr_loc_req_t;

  typedef enum logic [5:0] {
    S_IDLE = 6'h01,
    S_DECODE = 6'h02,
    S_WDATA = 6'h04,
    S_RWAIT = 6'h08,
    S_RDATA = 6'h10,
    S_END = 6'h20
  } pcidr_state_t;

  localparam int PIN_IN_W = $bits(pcidr_pin_in_t);

endpackage

// ### hw/pcidr_sync.sv
`timescale 1ns/100ps
module pcidr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] q_d;
  wire logic [W-1:0] agree = ~(s2_q ^ s3_q);

  // a bit changes only once the second and third stages agree
  assign q_d = (s2_q & agree) | (q & ~agree);

  always_ff @(posedge clock) begin
    if (rst) begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      q <= RST_VAL;
    end else begin
      s1_q <= d;
      s2_q <= s1_q;
      s3_q <= s2_q;
      q <= q_d;
    end
  end
endmodule

// ### verification/pcidr_target_chk.sv
`timescale 1ns/100ps
module pcidr_target_chk (
  input wire logic clock,
  input wire logic rst,
  input wire pcidr_pkg::pcidr_pin_out_t pci_out,
  input wire pcidr_pkg::pcidr_loc_req_t loc_req,
  input wire logic loc_req_valid,
  input wire logic loc_req_ready,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_rresp
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // both halves are latched first, the response follows one clock later
  wr_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##2 s_axi_bvalid) else $error("write response late");
  rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  unmapped_err_a: assert property (s_axi_arvalid && s_axi_arready
    && s_axi_araddr > pcidr_pkg::STATUS_OFF |=> s_axi_rresp == pcidr_pkg::RESP_SLVERR)
    else $error("unmapped read not refused");
  aw_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  loc_hold_a: assert property (loc_req_valid && !loc_req_ready
    |=> loc_req_valid && $stable(loc_req)) else $error("local request changed");
  stop_claim_a: assert property (!pci_out.stop_n
    |-> !pci_out.devsel_n && !pci_out.ctl_oe_n) else $error("stop without claim");
  data_drive_a: assert property ($fell(pci_out.ad_oe_n) |-> !pci_out.trdy_n)
    else $error("read data without trdy");
  ad_claim_a: assert property (!pci_out.ad_oe_n |-> !pci_out.ctl_oe_n && !pci_out.devsel_n)
    else $error("ad driven without claim");
  cover property ($fell(pci_out.stop_n));
  cover property ($fell(pci_out.ad_oe_n));
  cover property (loc_req_valid && loc_req_ready && loc_req.write);
endmodule
bind pcidr_target pcidr_target_chk pcidr_target_chk_inst (.clock, .rst, .pci_out, .loc_req,
  .loc_req_valid, .loc_req_ready, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rresp);

// ### verification/pcidr_master.sv
`timescale 1ns/100ps
module pcidr_master (
  input wire logic clock,
  output logic pci_clk,
  output pcidr_pkg::pcidr_pin_in_t pci_in,
  input wire pcidr_pkg::pcidr_pin_out_t pci_out
);
  pcidr_pkg::pcidr_pin_in_t drv = '1;
  initial pci_clk = 1'b0;
  always #40 pci_clk = ~pci_clk;
  // ad is a shared wire: the target's enable takes it over
  always_comb begin
    pci_in = drv;
    if (!pci_out.ad_oe_n) pci_in.ad = pci_out.ad;
  end
  task automatic step;
    @(negedge pci_clk);
    @(posedge clock);
  endtask
  // code 0 done, 1 stopped, 2 no answer
  task automatic go(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
      input int nw, input logic [31:0] wd, output int code, output int moved,
      output logic [31:0] rd);
    int n;
    moved = 0;
    code = 2;
    rd = '0;
    step();
    drv.frame_n <= 1'b0;
    drv.cbe_n <= cmd;
    drv.ad <= a;
    step();
    drv.irdy_n <= 1'b0;
    // frame_n rises with the last data phase
    drv.frame_n <= (nw < 2);
    drv.cbe_n <= be;
    drv.ad <= (cmd == pcidr_pkg::CMD_MEM_WR) ? wd : ~a;
    for (n = 0; n < 40 && code == 2; n++) begin
      @(posedge pci_clk);
      if (!pci_out.trdy_n) begin
        moved++;
        rd = pci_out.ad;
        if (moved == nw) code = 0;
      end else if (!pci_out.stop_n) code = 1;
      step();
      if (cmd == pcidr_pkg::CMD_MEM_WR) drv.ad <= wd + 32'(moved);
      if (moved == nw - 1) drv.frame_n <= 1'b1;
    end
    drv.frame_n <= 1'b1;
    drv.irdy_n <= 1'b1;
    drv.ad <= ~drv.ad;
    repeat (2) @(posedge pci_clk);
  endtask
endmodule

// ### verification/test_pci_target_delayed_read.sv
`timescale 1ns/100ps
module test_pci_target_delayed_read;
  localparam logic [31:0] KEY = 32'h5a5a0000;
  localparam logic [3:0] RD = pcidr_pkg::CMD_MEM_RD;
  localparam logic [3:0] WR = pcidr_pkg::CMD_MEM_WR;
  localparam logic [11:0] MODE = pcidr_pkg::MODE_ARB_OFF;
  localparam logic [11:0] LRD = pcidr_pkg::LOC_REGION_OFF;
  localparam logic [11:0] STAT = pcidr_pkg::STATUS_OFF;
  localparam logic [1:0] OK = pcidr_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = pcidr_pkg::RESP_SLVERR;
  localparam logic [31:0] C24 = 32'h1 << pcidr_pkg::COMPLY_BIT;
  localparam logic [31:0] B25 = 32'h1 << pcidr_pkg::NO_WRITE_BIT;
  localparam logic [31:0] B26 = 32'h1 << pcidr_pkg::WR_FLUSH_BIT;
  localparam logic [31:0] B28 = 32'h1 << pcidr_pkg::NO_FLUSH_BIT;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic pci_clk;
  pcidr_pkg::pcidr_pin_in_t pci_in;
  pcidr_pkg::pcidr_pin_out_t pci_out;
  pcidr_pkg::pcidr_loc_req_t loc_req, last_req;
  logic loc_req_valid, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic loc_req_ready = 1'b0, loc_rd_valid = 1'b0, stall = 1'b0, mute = 1'b0;
  logic [31:0] loc_rd_data = 32'h0, s_axi_wdata = 32'h0, s_axi_rdata, rdat;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrsp;
  int fails = 0, comparisons = 0, nreq = 0;
  always #5 clock = ~clock;
  pcidr_target #(.FLUSH_CLKS(64)) pcidr_target_inst (.clock, .rst, .pci_clk, .pci_in,
    .pci_out, .loc_req, .loc_req_valid, .loc_req_ready, .loc_rd_valid, .loc_rd_data,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  pcidr_master pcidr_master_inst (.clock, .pci_clk, .pci_in, .pci_out);
  // local bus: one-cycle ready, read data the cycle after acceptance
  always @(posedge clock) begin
    loc_rd_valid <= 1'b0;
    loc_req_ready <= !stall && loc_req_valid && !loc_req_ready;
    if (loc_req_valid && loc_req_ready) begin
      last_req <= loc_req;
      nreq <= nreq + 1;
      loc_rd_valid <= !loc_req.write && !mute;
      loc_rd_data <= loc_req.addr ^ KEY;
    end
  end
  task automatic conclude;
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    s_axi_bready <= 1'b0;
    check("write response", s_axi_bresp, er);
    if (n == 50) begin
      fails++;
      conclude();
    end
  endtask
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] er);
    int n;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clock);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rdat = s_axi_rdata;
    rrsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    check("register data", rdat, exp);
    check("register response", rrsp, er);
    if (n == 50) begin
      fails++;
      conclude();
    end
  endtask
  // ec: 0 completed, 1 retry or disconnect; em: words moved
  task automatic pr(input logic [3:0] cmd, input logic [31:0] a, input logic [3:0] be,
      input int nw, input int ec, input int em);
    int code, moved;
    logic [31:0] d;
    pcidr_master_inst.go(cmd, a, be, nw, a, code, moved, d);
    if (code == 2) begin
      fails++;
      conclude();
    end
    check("pci end code", code, ec);
    check("pci words moved", moved, em);
    if (cmd == RD && ec == 0) check("pci read data", d, a ^ KEY);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    repeat (8) @(posedge clock);
    rchk(LRD, pcidr_pkg::LOC_REGION_RST, OK);
    rchk(12'h010, 32'h0, ERR);
    axi_wr(12'h010, C24, ERR);
    axi_wr(STAT, 32'hf, OK);
    rchk(STAT, 32'h0, OK);
    rchk(MODE, pcidr_pkg::MODE_ARB_RST, OK);
    axi_wr(MODE, C24, OK);
    rchk(MODE, C24, OK);
    pr(RD, 32'h100, 4'h5, 1, 1, 0);
    check("local addr", last_req.addr, 32'h100);
    check("local enables", last_req.local_byte_enables_n, 4'h5);
    pr(RD, 32'h200, 4'h5, 1, 1, 0);
    pr(RD, 32'h100, 4'h6, 1, 1, 0);
    check("local count", nreq, 1);
    pr(RD, 32'h100, 4'h5, 1, 0, 1);
    pr(RD, 32'h300, 4'h0, 1, 1, 0);
    repeat (80) @(posedge pci_clk);
    pr(RD, 32'h400, 4'h0, 1, 1, 0);
    check("local addr", last_req.addr, 32'h400);
    pr(RD, 32'h400, 4'h0, 1, 0, 1);
    axi_wr(MODE, C24 | B25, OK);
    pr(RD, 32'h500, 4'h0, 1, 1, 0);
    pr(WR, 32'h800, 4'h0, 1, 1, 0);
    pr(RD, 32'h500, 4'h0, 1, 0, 1);
    axi_wr(MODE, C24 | B26, OK);
    pr(RD, 32'h600, 4'h0, 1, 1, 0);
    pr(WR, 32'h800, 4'h0, 2, 0, 2);
    check("local addr", last_req.addr, 32'h804);
    check("local write", last_req.write, 1'b1);
    check("local data", last_req.data, 32'h801);
    pr(RD, 32'h600, 4'h0, 1, 1, 0);
    pr(RD, 32'h600, 4'h0, 1, 0, 1);
    axi_wr(MODE, C24 | B28, OK);
    pr(RD, 32'h700, 4'ha, 1, 1, 0);
    check("local enables", last_req.local_byte_enables_n, 4'h0);
    pr(RD, 32'h700, 4'ha, 1, 0, 1);
    axi_wr(MODE, C24, OK);
    stall <= 1'b1;
    pr(WR, 32'h900, 4'h0, 3, 1, 1);
    pr(WR, 32'ha00, 4'h0, 1, 1, 0);
    rchk(STAT, 32'h4, OK);
    stall <= 1'b0;
    axi_wr(LRD, 32'h30000000, OK);
    axi_wr(MODE, 32'h0, OK);
    pr(RD, 32'hb00, 4'h3, 1, 0, 1);
    mute <= 1'b1;
    pr(RD, 32'hc00, 4'h3, 1, 1, 0);
    rchk(STAT, 32'h8, OK);
    conclude();
  end
endmodule
